// [hw/ext_irq_params.svh]
// Purpose: Offsets, field positions, reset values for the extended irq unit
// Assumes: APB word addressing, byte address = 4 x register index
// Notes:   Included by the top design module
`ifndef EXT_IRQ_PARAMS_SVH
`define EXT_IRQ_PARAMS_SVH
`define IDX_TIMER_CONTROL   8'h88
`define IDX_EXT_CONFIG      8'he4
`define IDX_ENABLE_TWO      8'he7
`define IDX_PRIORITY_TWO    8'hf7
`define RST_TIMER_CONTROL   8'h00
`define RST_EXT_CONFIG      8'h01
`define RST_ENABLE_TWO      4'h0
`define RST_PRIORITY_TWO    4'h0
`define BIT_RADIO           2
`define BIT_RTC             2
`define POS_RADIO           3
`define POS_RTC             2
`define POS_MATCH           1
`define POS_WARN            0
`define POS_ZERO_EDGE       0
`define POS_ZERO_PENDING    1
`define POS_ONE_EDGE        2
`define POS_ONE_PENDING     3
`define POS_ZERO_POL        3
`define POS_ONE_POL         7
`define POS_ZERO_SEL        0
`define POS_ONE_SEL         4
`endif

// [hw/ext_irq_pkg.sv]
// Purpose: Shared types for the extended irq unit
// Assumes: Constants live in ext_irq_params.svh
// Notes:   Four gated sources travel together in one struct
package ext_irq_pkg;
  typedef struct packed {
    logic radio_serial_port;
    logic rtc_osc_fail;
    logic port_match;
    logic supply_warning;
  } src_s;
  typedef enum logic [1:0] {
    idle,
    access
  } apb_state_e;
endpackage

// [hw/pin_sync.sv]
// Purpose: Two-flop synchroniser for the port 0 pins
// Assumes: Pins asynchronous to clk
// Notes:   First stage feeds only the second
`timescale 1ns/10ps
`default_nettype none
module pin_sync (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] d,
  output logic      [7:0] q
);
  logic [7:0] meta;
  logic [7:0] next_meta;
  logic [7:0] next_q;
  always_comb begin
    next_meta = d;
    next_q    = meta;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      // Idle high like a pulled-up pin, so active-low inputs start quiet
      meta <= 8'hff;
      q    <= 8'hff;
    end else begin
      meta <= next_meta;
      q    <= next_q;
    end
  end
endmodule
`default_nettype wire

// [hw/ext_pin_sense.sv]
// Purpose: One external interrupt input: select, polarity, edge or level
// Assumes: pins already synchronised
// Notes:   Pending flag registered here
`timescale 1ns/10ps
`default_nettype none
module ext_pin_sense (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] pins,
  input  wire logic [2:0] pin_select,
  input  wire logic       polarity,
  input  wire logic       edge_mode,
  input  wire logic       vector_ack,
  input  wire logic       sw_write,
  input  wire logic       sw_value,
  output logic            pending
);
  logic active;
  logic prev_active;
  logic next_prev_active;
  logic next_pending;
  always_comb begin
    active           = ~(pins[pin_select] ^ polarity);
    next_prev_active = active;
    next_pending     = pending;
    if (edge_mode) begin
      if (vector_ack || sw_write) begin
        next_pending = sw_write ? sw_value : 1'b0;
      end
      if (active && !prev_active) begin
        next_pending = 1'b1;
      end
    end else begin
      next_pending = active;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      // Start as active: a pin already active at reset raises no edge
      prev_active <= 1'b1;
      pending     <= 1'b0;
    end else begin
      prev_active <= next_prev_active;
      pending     <= next_pending;
    end
  end
endmodule
`default_nettype wire

// [hw/ext_irq_enable_priority_unit.sv]
// Purpose: Extended enable/priority two and external interrupt sensing
// Assumes: APB slave, one cycle access phase, zero wait states
// Notes:   Vectoring logic acknowledges external irqs by pulse
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "ext_irq_params.svh"
module ext_irq_enable_priority_unit (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [31:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire ext_irq_pkg::src_s  src_req,
  input  wire logic [7:0]         port0_pins,
  input  wire logic               ack_ext_zero,
  input  wire logic               ack_ext_one,
  output ext_irq_pkg::src_s       src_to_cpu,
  output ext_irq_pkg::src_s       src_high_priority,
  output logic                    ext_zero_request,
  output logic                    ext_one_request
);
  logic [3:0]  enable_two;
  logic [3:0]  priority_two;
  logic [7:0]  ext_config;
  logic [1:0]  edge_modes;
  logic [3:0]  timer_control_register_spare;
  logic [3:0]  next_enable_two;
  logic [3:0]  next_priority_two;
  logic [7:0]  next_ext_config;
  logic [1:0]  next_edge_modes;
  logic [3:0]  next_timer_control_register_spare;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  ext_irq_pkg::src_s next_src_to_cpu;
  ext_irq_pkg::src_s next_src_high;
  logic        next_zero_req;
  logic        next_one_req;
  logic [7:0]  pins_sync;
  logic        pend_zero;
  logic        pend_one;
  logic        wr;
  logic        setup;
  logic [7:0]  index;
  logic        hit;
  logic        timer_control_register_wr;
  logic [7:0]  timer_control_register_view;

  pin_sync u_sync (
    .clk (clk),
    .rst (rst),
    .d   (port0_pins),
    .q   (pins_sync)
  );

  ext_pin_sense u_zero (
    .clk        (clk),
    .rst        (rst),
    .pins       (pins_sync),
    .pin_select (ext_config[`POS_ZERO_SEL +: 3]),
    .polarity   (ext_config[`POS_ZERO_POL]),
    .edge_mode  (edge_modes[0]),
    .vector_ack (ack_ext_zero),
    .sw_write   (timer_control_register_wr),
    .sw_value   (pwdata[`POS_ZERO_PENDING]),
    .pending    (pend_zero)
  );

  ext_pin_sense u_one (
    .clk        (clk),
    .rst        (rst),
    .pins       (pins_sync),
    .pin_select (ext_config[`POS_ONE_SEL +: 3]),
    .polarity   (ext_config[`POS_ONE_POL]),
    .edge_mode  (edge_modes[1]),
    .vector_ack (ack_ext_one),
    .sw_write   (timer_control_register_wr),
    .sw_value   (pwdata[`POS_ONE_PENDING]),
    .pending    (pend_one)
  );

  always_comb begin
    setup   = psel && !penable;
    wr      = setup && pwrite;
    // Upper address bits must be zero for a hit
    index   = paddr[9:2];
    hit     = (paddr[31:10] == 22'h000000) && (paddr[1:0] == 2'b00);
    timer_control_register_wr = wr && hit && (index == `IDX_TIMER_CONTROL);
    timer_control_register_view = {timer_control_register_spare, pend_one, edge_modes[1], pend_zero,
                 edge_modes[0]};
    next_enable_two   = enable_two;
    next_priority_two = priority_two;
    next_ext_config   = ext_config;
    next_edge_modes   = edge_modes;
    next_timer_control_register_spare   = timer_control_register_spare;
    next_prdata       = 32'h00000000;
    next_pready       = setup;
    next_pslverr      = 1'b0;
    if (setup) begin
      if (!hit) begin
        next_pslverr = 1'b1;
      end else begin
        case (index)
          `IDX_ENABLE_TWO: begin
            next_prdata = {28'h0000000, enable_two};
            if (pwrite) begin
              next_enable_two = pwdata[3:0];
            end
          end
          `IDX_PRIORITY_TWO: begin
            next_prdata = {28'h0000000, priority_two};
            if (pwrite) begin
              next_priority_two = pwdata[3:0];
            end
          end
          `IDX_EXT_CONFIG: begin
            next_prdata = {24'h000000, ext_config};
            if (pwrite) begin
              next_ext_config = pwdata[7:0];
            end
          end
          `IDX_TIMER_CONTROL: begin
            next_prdata = {24'h000000, timer_control_register_view};
            if (pwrite) begin
              next_edge_modes = {pwdata[`POS_ONE_EDGE],
                                 pwdata[`POS_ZERO_EDGE]};
              next_timer_control_register_spare = pwdata[7:4];
            end
          end
          default: begin
            next_pslverr = 1'b1;
          end
        endcase
      end
    end
    next_src_to_cpu.radio_serial_port =
      src_req.radio_serial_port & enable_two[`POS_RADIO];
    next_src_to_cpu.rtc_osc_fail =
      src_req.rtc_osc_fail & enable_two[`POS_RTC];
    next_src_to_cpu.port_match =
      src_req.port_match & enable_two[`POS_MATCH];
    next_src_to_cpu.supply_warning =
      src_req.supply_warning & enable_two[`POS_WARN];
    next_src_high.radio_serial_port = priority_two[`POS_RADIO];
    next_src_high.rtc_osc_fail      = priority_two[`POS_RTC];
    next_src_high.port_match        = priority_two[`POS_MATCH];
    next_src_high.supply_warning    = priority_two[`POS_WARN];
    next_zero_req = pend_zero;
    next_one_req  = pend_one;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      enable_two        <= `RST_ENABLE_TWO;
      priority_two      <= `RST_PRIORITY_TWO;
      ext_config        <= `RST_EXT_CONFIG;
      edge_modes        <= 2'b00;
      timer_control_register_spare        <= 4'h0;
      prdata            <= 32'h00000000;
      pready            <= 1'b0;
      pslverr           <= 1'b0;
      src_to_cpu        <= '0;
      src_high_priority <= '0;
      ext_zero_request  <= 1'b0;
      ext_one_request   <= 1'b0;
    end else begin
      enable_two        <= next_enable_two;
      priority_two      <= next_priority_two;
      ext_config        <= next_ext_config;
      edge_modes        <= next_edge_modes;
      timer_control_register_spare        <= next_timer_control_register_spare;
      prdata            <= next_prdata;
      pready            <= next_pready;
      pslverr           <= next_pslverr;
      src_to_cpu        <= next_src_to_cpu;
      src_high_priority <= next_src_high;
      ext_zero_request  <= next_zero_req;
      ext_one_request   <= next_one_req;
    end
  end
endmodule
`default_nettype wire

// [dv/ext_irq_asserts.sv]
// Purpose: Port checks for the extended irq unit
// Assumes: Zero wait APB, registered outputs
// Notes:   No register mirror, so checks stay at the ports
`timescale 1ns/10ps
`default_nettype none
module ext_irq_asserts (
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [31:0]       paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire ext_irq_pkg::src_s src_req,
  input wire logic [7:0]        port0_pins,
  input wire logic              ack_ext_zero,
  input wire logic              ack_ext_one,
  input wire ext_irq_pkg::src_s src_to_cpu,
  input wire ext_irq_pkg::src_s src_high_priority,
  input wire logic              ext_zero_request,
  input wire logic              ext_one_request
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence setup_s;
    psel && !penable;
  endsequence
  pready_a: assert property (setup_s |=> pready) else $error("no pready");
  stray_ready_a: assert property (pready |-> $past(psel && !penable))
    else $error("stray pready");
  bad_align_a: assert property (setup_s ##0 paddr[1:0] != 2'h0 |=> pslverr)
    else $error("misaligned not refused");
  upper_zero_a: assert property (setup_s ##0 (!pwrite &&
    (paddr == 32'h39c || paddr == 32'h3dc)) |=> prdata[31:4] == 28'h0)
    else $error("upper bits set");
  gate_a: assert property ((src_to_cpu & ~$past(src_req)) == 4'h0)
    else $error("source passed without request");
  prio_copy_a: assert property (setup_s ##0 (pwrite &&
    paddr == 32'h3dc) |-> ##2 src_high_priority == $past(pwdata[3:0], 2))
    else $error("priority output wrong");
  pend_read_a: assert property (setup_s ##0 (!pwrite &&
    paddr == 32'h220) |=> prdata[1] == ext_zero_request &&
    prdata[3] == ext_one_request) else $error("pending bits misplaced");
  reset_zero_a: assert property ($fell(rst) |-> src_to_cpu == 4'h0 &&
    src_high_priority == 4'h0) else $error("not cleared by reset");
endmodule
bind ext_irq_enable_priority_unit ext_irq_asserts asserts_u (.*);
`default_nettype wire

// [dv/pin_partner.sv]
// Purpose: External requester driving the port 0 pins
// Assumes: Pins change just after a clock edge
// Notes:   A held level request stays active until the device sees it
`timescale 1ns/10ps
`default_nettype none
module pin_partner (
  input  wire logic       clk,
  input  wire logic [7:0] want,
  input  wire logic       hold,
  input  wire logic       seen,
  output logic      [7:0] pins
);
  always_ff @(posedge clk) begin
    if (!hold || seen) begin
      pins <= want;
    end
  end
endmodule
`default_nettype wire

// [dv/tb.sv]
// Purpose: Self-checking bench for the extended irq unit
// Assumes: Zero wait APB slave, 4 ns clock
// Notes:   Random enables, priorities, requests and polarities
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic              clk = 1'h0;
  logic              rst = 1'h1;
  logic              psel = 1'h0;
  logic              penable = 1'h0;
  logic              pwrite = 1'h0;
  logic       [31:0] paddr = 32'h0;
  logic       [31:0] pwdata = 32'h0;
  logic       [31:0] prdata;
  logic              pready;
  logic              pslverr;
  ext_irq_pkg::src_s src_req = 4'h0;
  ext_irq_pkg::src_s src_to_cpu;
  ext_irq_pkg::src_s src_high_priority;
  logic        [7:0] want = 8'hff;
  logic        [7:0] port0_pins;
  logic              ack_ext_zero = 1'h0;
  logic              ack_ext_one = 1'h0;
  logic              ext_zero_request;
  logic              ext_one_request;
  logic              hold = 1'h0;
  logic        [1:0] req;
  logic       [31:0] rd;
  logic       [31:0] d;
  logic              err;
  logic              pol;
  int                fails = 0;
  int                compares = 0;
  int                seed = 52383;
  int                k = 0;
  int                s;
  int                n;
  assign req = {ext_one_request, ext_zero_request};
  always #2 clk = ~clk;
  ext_irq_enable_priority_unit dut_u (.*);
  pin_partner partner_u (.clk(clk), .want(want), .hold(hold),
    .seen(req[k]), .pins(port0_pins));
  function automatic logic [7:0] cfg_of(input int j, input int p,
    input logic v);
    return j ? {v, 3'(p), 4'h0} : {4'h0, v, 3'(p)};
  endfunction
  task automatic chk(input string nm, input logic [31:0] got,
    input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a,
    input logic [31:0] wd);
    int t;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'h1;
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (pready !== 1'h1 && t < 20);
    if (pready !== 1'h1) begin
      fails++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic report_and_stop;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #100000;
    fails++;
    report_and_stop;
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    apb(1'h0, 32'h39c, 32'h0);
    chk("enable reset", rd, 32'h0);
    apb(1'h0, 32'h3dc, 32'h0);
    chk("priority reset", rd, 32'h0);
    apb(1'h0, 32'h390, 32'h0);
    chk("config reset", rd, 32'h1);
    apb(1'h1, 32'h4, 32'hff);
    chk("unmapped", {31'h0, err}, 32'h1);
    apb(1'h1, 32'h39e, 32'hff);
    chk("misaligned", {31'h0, err}, 32'h1);
    for (n = 0; n < 20; n++) begin
      d = n == 0 ? 32'hffffffff : $random(seed);
      apb(1'h1, 32'h39c, d);
      apb(1'h0, 32'h39c, 32'h0);
      chk("enable rd", rd, {28'h0, d[3:0]});
      apb(1'h1, 32'h3dc, ~d);
      apb(1'h0, 32'h3dc, 32'h0);
      chk("priority rd", rd, {28'h0, ~d[3:0]});
      src_req <= 4'($random(seed));
      repeat (3) @(posedge clk);
      chk("to cpu", {28'h0, src_to_cpu}, {28'h0, src_req & d[3:0]});
      chk("high", {28'h0, src_high_priority}, {28'h0, ~d[3:0]});
    end
    for (k = 0; k < 2; k++) begin
      for (s = 0; s < 8; s++) begin
        pol = 1'($random(seed));
        apb(1'h1, 32'h220, 32'h0);
        want <= {8{~pol}};
        repeat (6) @(posedge clk);
        apb(1'h1, 32'h390, {24'h0, cfg_of(k, s, pol)});
        apb(1'h0, 32'h390, 32'h0);
        chk("config rd", rd, {24'h0, cfg_of(k, s, pol)});
        want[s] <= pol;
        @(posedge clk);
        hold <= 1'h1;
        want <= {8{~pol}};
        for (n = 0; n < 10 && req[k] !== 1'h1; n++)
          @(posedge clk);
        chk("level set", {31'h0, req[k]}, 32'h1);
        repeat (6) @(posedge clk);
        chk("level clear", {31'h0, req[k]}, 32'h0);
        hold <= 1'h0;
        apb(1'h1, 32'h220, k ? 32'h4 : 32'h1);
        want[s] <= pol;
        repeat (6) @(posedge clk);
        chk("edge set", {31'h0, req[k]}, 32'h1);
        apb(1'h0, 32'h220, 32'h0);
        chk("pending rd", {30'h0, rd[2*k+1], rd[2*k]}, 32'h3);
        ack_ext_zero <= k == 0;
        ack_ext_one <= k == 1;
        @(posedge clk);
        ack_ext_zero <= 1'h0;
        ack_ext_one <= 1'h0;
        repeat (4) @(posedge clk);
        chk("edge clear", {31'h0, req[k]}, 32'h0);
      end
    end
    report_and_stop;
  end
endmodule
`default_nettype wire
